/* File: core/fpd_defines.svh */
// Timing and layout constants for the fast-page DRAM controller
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH
`define FPD_CLK_PS 4000
`define FPD_ADDR_W 16
`define FPD_ROW_W 8
`define FPD_DATA_W 18
`define FPD_LANE_W 9
`define FPD_ROWS 256
`define FPD_INIT_CYCLES 8
`define FPD_POWERUP_US 500
`define FPD_POWERUP_CYC ((`FPD_POWERUP_US * 1000000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`define FPD_REF_STD_MS 4
`define FPD_REF_EXT_MS 32
`define FPD_CLK_NS (`FPD_CLK_PS / 1000)
`define FPD_REF_STD_INT ((`FPD_REF_STD_MS * 1000000 / `FPD_CLK_NS) / `FPD_ROWS)
`define FPD_REF_EXT_INT ((`FPD_REF_EXT_MS * 1000000 / `FPD_CLK_NS) / `FPD_ROWS)
`define FPD_IDLE_MS 4
`define FPD_IDLE_CYC (`FPD_IDLE_MS * 1000000 / `FPD_CLK_NS)
`define FPD_RP_NS 45
`define FPD_RP_CYC ((`FPD_RP_NS * 1000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`define FPD_RAS_NS 130
`define FPD_RAS_CYC ((`FPD_RAS_NS * 1000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`define FPD_RCD_NS 20
`define FPD_RCD_CYC ((`FPD_RCD_NS * 1000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`define FPD_CAS_NS 60
`define FPD_CAS_CYC ((`FPD_CAS_NS * 1000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`define FPD_CSR_NS 5
`define FPD_CSR_CYC ((`FPD_CSR_NS * 1000 + `FPD_CLK_PS - 1) / `FPD_CLK_PS)
`endif

/* File: core/fpd_pkg.sv */
// Types shared by the fast-page DRAM controller
`default_nettype none
`include "fpd_defines.svh"
package fpd_pkg;
  typedef struct packed {
    logic row_strobe_n;
    logic lower_col_strobe_n;
    logic upper_col_strobe_n;
    logic write_en_n;
    logic out_en_n;
    logic [`FPD_ROW_W-1:0] addr;
  } fpd_pins_t;
  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [`FPD_ADDR_W-1:0] addr;
    logic [`FPD_DATA_W-1:0] wdata;
  } fpd_req_t;
  typedef enum logic [3:0] {
    FPD_POWERUP = 4'h0,
    FPD_INIT = 4'h1,
    FPD_IDLE = 4'h2,
    FPD_ROW = 4'h3,
    FPD_COL = 4'h4,
    FPD_PRECHARGE = 4'h5,
    FPD_CBR_SETUP = 4'h6,
    FPD_CBR_RAS = 4'h7,
    FPD_SELF = 4'h8
  } fpd_state_t;
endpackage : fpd_pkg
`default_nettype wire

/* File: core/fpd_refresh_timer.sv */
// Refresh interval and idle-row-strobe timer
`default_nettype none
`include "fpd_defines.svh"
module fpd_refresh_timer
  import fpd_pkg::*;
#(
  parameter int unsigned STD_INT = `FPD_REF_STD_INT,
  parameter int unsigned EXT_INT = `FPD_REF_EXT_INT,
  parameter int unsigned IDLE_CYC = `FPD_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic extended_mode,
  input wire logic ras_active,
  input wire logic refresh_done,
  output logic refresh_due,
  output logic idle_expired
);
  logic [23:0] int_cnt_q;
  logic [23:0] idle_cnt_q;
  logic [23:0] limit;

  assign limit = extended_mode ? 24'(EXT_INT) : 24'(STD_INT);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_cnt_q <= 24'h000000;
      refresh_due <= 1'b0;
    end else if (clk_en) begin
      if (int_cnt_q >= limit - 24'h000001) begin
        int_cnt_q <= 24'h000000;
        refresh_due <= 1'b1;
      end else begin
        int_cnt_q <= int_cnt_q + 24'h000001;
        if (refresh_done) begin
          refresh_due <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt_q <= 24'h000000;
      idle_expired <= 1'b0;
    end else if (clk_en) begin
      if (ras_active) begin
        idle_cnt_q <= 24'h000000;
        idle_expired <= 1'b0;
      end else if (idle_cnt_q >= 24'(IDLE_CYC)) begin
        idle_expired <= 1'b1;
      end else begin
        idle_cnt_q <= idle_cnt_q + 24'h000001;
      end
      if (refresh_done && idle_expired && !(idle_cnt_q >= 24'(IDLE_CYC) && !ras_active)) begin
        idle_expired <= 1'b0;
      end
    end
  end
endmodule : fpd_refresh_timer
`default_nettype wire

/* File: core/fpd_ctrl.sv */
// Host controller that drives a 64K x 18 fast-page DRAM over its pins
// Operation
// - Row address presented at row strobe fall, column at column strobe fall.
// - All 256 rows refreshed within every 4 ms on standard parts.
// - Extended parts may spread 256 row refreshes over 32 ms.
// - Early write supplies data on enabled lanes; device outputs stay floating.
// - Delayed write and read-modify-write assert all strobes with data supplied.
// - Row-only refresh asserts row strobe with row address, write enable off.
// - After power-up wait 500 us then issue eight row-strobe cycles.
// - Row strobe may toggle during the power-up pause.
// - After row strobe idle beyond 4 ms issue eight cycles before use.
// - Eight column-before-row cycles precede reliance on that refresh mode; only self refresh waits for them, regular refresh does not.
`default_nettype none
`include "fpd_defines.svh"
module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = `FPD_POWERUP_CYC,
  parameter int unsigned STD_INT = `FPD_REF_STD_INT,
  parameter int unsigned EXT_INT = `FPD_REF_EXT_INT,
  parameter int unsigned IDLE_CYC = `FPD_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic extended_mode,
  input wire logic self_refresh_req,
  input wire logic req_valid,
  output logic req_ready,
  input wire fpd_req_t req,
  output logic rsp_valid,
  output logic [`FPD_DATA_W-1:0] rsp_rdata,
  output logic init_done,
  output logic in_self_refresh,
  output fpd_pins_t pins,
  output logic [`FPD_DATA_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  input wire logic [`FPD_DATA_W-1:0] dq_in
);
  localparam logic [7:0] RP_C = 8'(`FPD_RP_CYC);
  localparam logic [7:0] RAS_C = 8'(`FPD_RAS_CYC);
  localparam logic [7:0] RCD_C = 8'(`FPD_RCD_CYC);
  localparam logic [7:0] CAS_C = 8'(`FPD_CAS_CYC);
  localparam logic [7:0] CSR_C = 8'(`FPD_CSR_CYC);

  fpd_state_t state_q;
  fpd_req_t cur_q;
  logic [23:0] pu_cnt_q;
  logic [7:0] tim_q;
  logic [3:0] init_cnt_q;
  logic cbr_ready_q;
  logic [3:0] cbr_cnt_q;
  logic refresh_due;
  logic idle_expired;
  logic refresh_done;
  logic ras_active;

  function automatic logic [7:0] row_of(input logic [`FPD_ADDR_W-1:0] a);
    return a[15:8];
  endfunction : row_of

  function automatic logic [7:0] col_of(input logic [`FPD_ADDR_W-1:0] a);
    return a[7:0];
  endfunction : col_of

  assign ras_active = !pins.row_strobe_n;
  // Only a column-before-row cycle advances the device row counter
  assign refresh_done = (state_q == FPD_CBR_RAS) && tim_q == 8'h00
    && pins.row_strobe_n == 1'b0;
  // Ready mirrors exactly the idle branch that takes a request
  assign req_ready = (state_q == FPD_IDLE) && tim_q == 8'h00 && !refresh_due && !idle_expired
    && !(self_refresh_req && extended_mode) && clk_en;

  fpd_refresh_timer #(
    .STD_INT(STD_INT),
    .EXT_INT(EXT_INT),
    .IDLE_CYC(IDLE_CYC)
  ) u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .extended_mode(extended_mode),
    .ras_active(ras_active),
    .refresh_done(refresh_done),
    .refresh_due(refresh_due),
    .idle_expired(idle_expired)
  );

  // Main sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FPD_POWERUP;
      pu_cnt_q <= 24'h000000;
      tim_q <= 8'h00;
      init_cnt_q <= 4'h0;
      cur_q <= '0;
      init_done <= 1'b0;
      cbr_ready_q <= 1'b0;
      cbr_cnt_q <= 4'h0;
      pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
      dq_oe <= 2'b00;
      dq_out <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      in_self_refresh <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (tim_q != 8'h00) begin
        tim_q <= tim_q - 8'h01;
      end
      unique case (state_q)
        FPD_POWERUP: begin
          // Row strobe held high through the pause
          if (pu_cnt_q >= 24'(POWERUP_CYC)) begin
            state_q <= FPD_INIT;
            tim_q <= RP_C;
          end else begin
            pu_cnt_q <= pu_cnt_q + 24'h000001;
          end
        end
        FPD_INIT: begin
          if (tim_q == 8'h00) begin
            if (pins.row_strobe_n) begin
              pins.row_strobe_n <= 1'b0;
              pins.write_en_n <= 1'b1;
              pins.addr <= {4'h0, init_cnt_q};
              tim_q <= RAS_C;
            end else begin
              pins.row_strobe_n <= 1'b1;
              tim_q <= RP_C;
              if (init_cnt_q == 4'(`FPD_INIT_CYCLES - 1)) begin
                init_cnt_q <= 4'h0;
                state_q <= FPD_IDLE;
                init_done <= 1'b1;
              end else begin
                init_cnt_q <= init_cnt_q + 4'h1;
              end
            end
          end
        end
        FPD_IDLE: begin
          if (tim_q == 8'h00) begin
            if (idle_expired) begin
              state_q <= FPD_INIT;
              init_done <= 1'b0;
            end else if (self_refresh_req && extended_mode && cbr_ready_q) begin
              state_q <= FPD_CBR_SETUP;
              pins.lower_col_strobe_n <= 1'b0;
              pins.upper_col_strobe_n <= 1'b0;
              tim_q <= CSR_C;
            end else if (refresh_due || (self_refresh_req && extended_mode)) begin
              state_q <= FPD_CBR_SETUP;
              pins.lower_col_strobe_n <= 1'b0;
              pins.upper_col_strobe_n <= 1'b0;
              tim_q <= CSR_C;
            end else if (req_valid) begin
              cur_q <= req;
              pins.addr <= row_of(req.addr);
              pins.row_strobe_n <= 1'b0;
              pins.write_en_n <= !req.write;
              pins.out_en_n <= 1'b1;
              state_q <= FPD_ROW;
              tim_q <= RCD_C;
            end
          end
        end
        FPD_ROW: begin
          // Column address set before strobe to stay under access reference
          pins.addr <= col_of(cur_q.addr);
          if (cur_q.write) begin
            dq_out <= cur_q.wdata;
            dq_oe <= cur_q.lanes;
          end else begin
            pins.out_en_n <= 1'b0;
          end
          if (tim_q == 8'h00) begin
            pins.lower_col_strobe_n <= !cur_q.lanes[0];
            pins.upper_col_strobe_n <= !cur_q.lanes[1];
            state_q <= FPD_COL;
            tim_q <= CAS_C;
          end
        end
        FPD_COL: begin
          if (tim_q == 8'h00) begin
            if (!cur_q.write) begin
              rsp_rdata <= dq_in;
              rsp_valid <= 1'b1;
            end
            pins.lower_col_strobe_n <= 1'b1;
            pins.upper_col_strobe_n <= 1'b1;
            pins.out_en_n <= 1'b1;
            pins.write_en_n <= 1'b1;
            dq_oe <= 2'b00;
            state_q <= FPD_PRECHARGE;
            tim_q <= (RAS_C > RCD_C + CAS_C) ? RAS_C - RCD_C - CAS_C : 8'h00;
          end
        end
        FPD_PRECHARGE: begin
          if (tim_q == 8'h00) begin
            pins.row_strobe_n <= 1'b1;
            state_q <= FPD_IDLE;
            tim_q <= RP_C;
          end
        end
        FPD_CBR_SETUP: begin
          if (tim_q == 8'h00) begin
            pins.row_strobe_n <= 1'b0;
            state_q <= FPD_CBR_RAS;
            tim_q <= RAS_C;
          end
        end
        FPD_CBR_RAS: begin
          if (tim_q == 8'h00) begin
            if (self_refresh_req && extended_mode && cbr_ready_q) begin
              state_q <= FPD_SELF;
              in_self_refresh <= 1'b1;
            end else begin
              pins.row_strobe_n <= 1'b1;
              pins.lower_col_strobe_n <= 1'b1;
              pins.upper_col_strobe_n <= 1'b1;
              state_q <= FPD_IDLE;
              tim_q <= RP_C;
              if (cbr_cnt_q == 4'(`FPD_INIT_CYCLES - 1)) begin
                cbr_ready_q <= 1'b1;
              end else begin
                cbr_cnt_q <= cbr_cnt_q + 4'h1;
              end
            end
          end
        end
        FPD_SELF: begin
          if (!self_refresh_req) begin
            pins.row_strobe_n <= 1'b1;
            pins.lower_col_strobe_n <= 1'b1;
            pins.upper_col_strobe_n <= 1'b1;
            in_self_refresh <= 1'b0;
            state_q <= FPD_IDLE;
            tim_q <= RP_C;
          end
        end
        default: begin
          state_q <= FPD_IDLE;
        end
      endcase
    end
  end
endmodule : fpd_ctrl
`default_nettype wire

/* File: verification/fpd_ctrl_properties.sv */
// Concurrent checks on the fast-page DRAM controller ports
`default_nettype none
`include "fpd_defines.svh"
module fpd_ctrl_properties
  import fpd_pkg::*;
#(
  parameter int unsigned STD_INT = 200,
  parameter int unsigned EXT_INT = 400
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic extended_mode,
  input wire logic self_refresh_req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire fpd_req_t req,
  input wire logic rsp_valid,
  input wire logic [`FPD_DATA_W-1:0] rsp_rdata,
  input wire logic init_done,
  input wire logic in_self_refresh,
  input wire fpd_pins_t pins,
  input wire logic [`FPD_DATA_W-1:0] dq_out,
  input wire logic [1:0] dq_oe,
  input wire logic [`FPD_DATA_W-1:0] dq_in
);
  logic prev_row_q;
  logic took_q;
  logic [15:0] addr_q;
  logic [3:0] rows_q;
  logic [3:0] cbrs_q;
  logic [31:0] gap_q;
  wire logic cas_low = !(pins.lower_col_strobe_n && pins.upper_col_strobe_n);
  wire logic row_fall = prev_row_q && !pins.row_strobe_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Strobe edges and accepted address
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_row_q <= 1'b1;
      took_q <= 1'b0;
      addr_q <= '0;
    end else begin
      prev_row_q <= pins.row_strobe_n;
      took_q <= req_valid && req_ready && clk_en;
      if (req_valid && req_ready && clk_en) addr_q <= req.addr;
    end
  end
  // Row-cycle and refresh-cycle counts, gap since last row strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rows_q <= '0;
      cbrs_q <= '0;
      gap_q <= '0;
    end else begin
      if (row_fall && !cas_low && rows_q != 4'hF) rows_q <= rows_q + 4'h1;
      if (row_fall && cas_low && cbrs_q != 4'hF) cbrs_q <= cbrs_q + 4'h1;
      if (row_fall || !init_done || in_self_refresh) gap_q <= '0;
      else if (clk_en) gap_q <= gap_q + 32'h1;
    end
  end
  a_row_addr: assert property (took_q |-> !pins.row_strobe_n && pins.addr == addr_q[15:8])
    else $error("row address wrong at row strobe");
  a_col_addr: assert property (!pins.row_strobe_n && ($fell(pins.lower_col_strobe_n)
    || $fell(pins.upper_col_strobe_n)) |-> pins.addr == addr_q[7:0])
    else $error("column address wrong at column strobe");
  a_write_drive_only: assert property (dq_oe != 2'b00 |-> !pins.write_en_n && !pins.row_strobe_n)
    else $error("data driven outside a write");
  a_lane_select: assert property (dq_oe != 2'b00 && cas_low
    |-> dq_oe == ~{pins.upper_col_strobe_n, pins.lower_col_strobe_n})
    else $error("driven lanes differ from column strobes");
  a_cbr_setup: assert property (row_fall && cas_low
    |-> dq_oe == 2'b00 && $past(pins.lower_col_strobe_n) == 1'b0)
    else $error("refresh without column setup or with data driven");
  a_init_eight: assert property ($rose(init_done) |-> rows_q >= 4'd8)
    else $error("ready before eight row cycles");
  a_self_after_cbr: assert property ($rose(in_self_refresh)
    |-> extended_mode && cbrs_q >= 4'd8)
    else $error("self refresh entered too early");
  a_refresh_gap: assert property (gap_q <= (extended_mode ? EXT_INT : STD_INT) + 32'd128)
    else $error("refresh interval exceeded");
  c_read: cover property (rsp_valid);
  c_self: cover property ($rose(in_self_refresh));
  c_lane: cover property (dq_oe == 2'b01 && cas_low);
endmodule : fpd_ctrl_properties
`default_nettype wire

/* File: verification/fpd_dram_model.sv */
// Behavioural 64K x 18 fast-page DRAM on the controller pins
`default_nettype none
module fpd_dram_model
  import fpd_pkg::*;
(
  input wire logic core_clk,
  input wire fpd_pins_t pins,
  input wire logic [17:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [17:0] dq_in,
  output var int row_cycles,
  output var int cbr_cycles
);
  logic [17:0] mem [0:65535];
  logic [7:0] row_q;
  logic [7:0] col_q;
  logic [17:0] flt_q = 18'h2AAAA;
  logic [1:0] drv;
  initial begin
    row_cycles = 0;
    cbr_cycles = 0;
  end
  // Released lanes show a pattern that changes every cycle
  always @(posedge core_clk) flt_q <= ~flt_q;
  always @(negedge pins.row_strobe_n) begin
    if (pins.lower_col_strobe_n && pins.upper_col_strobe_n) begin
      row_q = pins.addr;
      row_cycles++;
    end else cbr_cycles++;
  end
  always @(negedge pins.lower_col_strobe_n) if (!pins.row_strobe_n) begin
    col_q = pins.addr;
    if (!pins.write_en_n) mem[{row_q, pins.addr}][8:0] = dq_out[8:0];
  end
  always @(negedge pins.upper_col_strobe_n) if (!pins.row_strobe_n) begin
    col_q = pins.addr;
    if (!pins.write_en_n) mem[{row_q, pins.addr}][17:9] = dq_out[17:9];
  end
  // Lanes drive only on a read with their column strobe low
  assign drv = {2{!pins.row_strobe_n && pins.write_en_n && !pins.out_en_n}}
    & ~{pins.upper_col_strobe_n, pins.lower_col_strobe_n};
  assign dq_in[8:0] = dq_oe[0] ? dq_out[8:0] : drv[0] ? mem[{row_q, col_q}][8:0] : flt_q[8:0];
  assign dq_in[17:9] = dq_oe[1] ? dq_out[17:9] : drv[1] ? mem[{row_q, col_q}][17:9] : flt_q[17:9];
endmodule : fpd_dram_model
`default_nettype wire

/* File: verification/fpd_ctrl_test.sv */
// Self-checking testbench for the fast-page DRAM controller
`default_nettype none
`include "fpd_defines.svh"
module fpd_ctrl_test;
  import fpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STD_I = 200;
  localparam int EXT_I = 400;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, extended_mode = 0, self_refresh_req = 0;
  logic req_valid = 0, req_ready, rsp_valid, init_done, in_self_refresh;
  fpd_req_t req = '0;
  fpd_pins_t pins;
  logic [17:0] rsp_rdata, dq_out, dq_in;
  logic [1:0] dq_oe;
  int row_cycles, cbr_cycles, fails = 0, compares = 0, cyc = 0;
  logic [17:0] shadow [int];
  logic [35:0] expq [$];
  fpd_ctrl #(.POWERUP_CYC(20), .STD_INT(STD_I), .EXT_INT(EXT_I), .IDLE_CYC(1000)) u_dut (
    .core_clk, .sys_rst, .clk_en, .extended_mode, .self_refresh_req, .req_valid, .req_ready,
    .req, .rsp_valid, .rsp_rdata, .init_done, .in_self_refresh, .pins, .dq_out, .dq_oe, .dq_in);
  fpd_dram_model u_mem (.core_clk, .pins, .dq_out, .dq_oe, .dq_in, .row_cycles, .cbr_cycles);
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end
  end
  // Oldest noted read is matched against each response
  always @(posedge core_clk) if (rsp_valid === 1'b1) begin
    logic [35:0] e;
    e = (expq.size() > 0) ? expq.pop_front() : 36'hF_FFFF_FFFF;
    chk("read data", {18'h0, rsp_rdata & e[35:18]}, {18'h0, e[17:0]});
  end
  task automatic access(input logic wr, input logic [1:0] ln, input logic [15:0] ad,
                        input logic [17:0] d);
    logic [17:0] m;
    m = {{9{ln[1]}}, {9{ln[0]}}};
    req = '{write: wr, lanes: ln, addr: ad, wdata: d};
    req_valid = 1'b1;
    do @(posedge core_clk); while (req_ready !== 1'b1 || clk_en !== 1'b1);
    if (wr) shadow[ad] = (shadow[ad] & ~m) | (d & m);
    else expq.push_back({m, shadow[ad] & m});
    #1;
  endtask : access
  task automatic wait_init();
    int r0;
    int t0;
    r0 = row_cycles;
    t0 = cyc;
    sys_rst = 1'b0;
    while (init_done !== 1'b1) @(posedge core_clk);
    chk("init rows", row_cycles - r0 >= 8, 1'b1);
    chk("init pause", cyc - t0 >= 20 + 8 * `FPD_RAS_CYC, 1'b1);
    #1;
  endtask : wait_init
  task automatic wait_self(input logic lvl);
    for (int i = 0; i < 1000 && in_self_refresh !== lvl; i++) @(posedge core_clk);
    #1;
  endtask : wait_self
  initial begin
    logic [15:0] a [6];
    int c0;
    void'($urandom(32'hBFE7CB94));
    repeat (8) @(posedge core_clk);
    #1;
    wait_init();
    self_refresh_req = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      access(1'b1, 2'b11, a[i], 18'($urandom));
    end
    for (int i = 0; i < 6; i++) access(1'b1, 2'(i % 2 + 1), a[i], 18'($urandom));
    for (int i = 0; i < 18; i++) access(1'b0, 2'(i % 3 + 1), a[i % 6], '0);
    chk("self without extended", in_self_refresh, 1'b0);
    req_valid = 1'b0;
    self_refresh_req = 1'b0;
    clk_en = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 clk_en = 1'b1;
    c0 = cbr_cycles;
    repeat (2000) @(posedge core_clk);
    chk("std refresh", cbr_cycles - c0 >= 2000 / STD_I - 1, 1'b1);
    #1 extended_mode = 1'b1;
    c0 = cbr_cycles;
    repeat (2000) @(posedge core_clk);
    chk("ext refresh", (cbr_cycles - c0) inside {[2000 / EXT_I - 1 : 2000 / EXT_I + 1]}, 1'b1);
    #1 self_refresh_req = 1'b1;
    wait_self(1'b1);
    chk("self entry", in_self_refresh, 1'b1);
    chk("self strobes", {pins.row_strobe_n, pins.lower_col_strobe_n}, 2'b00);
    self_refresh_req = 1'b0;
    wait_self(1'b0);
    chk("self exit", in_self_refresh, 1'b0);
    for (int i = 0; i < 6; i++) access(1'b0, 2'b11, a[i], '0);
    access(1'b0, 2'b11, a[0], '0);
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b1;
    req_valid = 1'b0;
    expq.delete();
    repeat (8) @(posedge core_clk);
    #1;
    wait_init();
    for (int i = 0; i < 6; i++) access(1'b0, 2'b11, a[i], '0);
    req_valid = 1'b0;
    repeat (100) @(posedge core_clk);
    chk("pending reads", expq.size(), 0);
    conclude();
  end
endmodule : fpd_ctrl_test
bind fpd_ctrl fpd_ctrl_properties #(.STD_INT(STD_INT), .EXT_INT(EXT_INT)) u_props (
  .core_clk, .sys_rst, .clk_en, .extended_mode, .self_refresh_req, .req_valid, .req_ready,
  .req, .rsp_valid, .rsp_rdata, .init_done, .in_self_refresh, .pins, .dq_out, .dq_oe, .dq_in);
`default_nettype wire
